// ==== qfd_pkg.sv ====
// Shared constants for the quad driver fault readout link and its host controller
package qfd_pkg;
   // Fault register layout
   localparam int CH_N = 4;
   localparam int FLT_W = 4;
   localparam int REG_W = 16;
   localparam int FLT_OT = 3;
   localparam int FLT_SB = 2;
   localparam int FLT_SG = 1;
   localparam int FLT_OL = 0;
   localparam logic [15:0] FAULT_RST = 16'h0000;
   // Pin synchroniser: {cs_n, sclk, cascade, in[4], ot[4], oc[4], low[4], mid[4]}
   localparam int DEV_SYNC_W = 23;
   localparam logic [22:0] DEV_SYNC_RST = 23'h400000;
   // Timing
   localparam int MCLK_PERIOD_NS = 100;
   localparam int FILT_DELAY_NS = 12000;
   localparam int FILT_CYC = (FILT_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int SCLK_HALF_NS = 400;
   localparam int SCLK_HALF_CYC = SCLK_HALF_NS / MCLK_PERIOD_NS;
   localparam int CS_SETUP_NS = 800;
   localparam int CS_SETUP_CYC = (CS_SETUP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   // Host controller register map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_DATA0 = 4'h8;
   localparam int CTRL_START = 0;
   localparam int CTRL_NCH_LSB = 8;
   localparam int CTRL_NCH_W = 4;
   localparam int STAT_BUSY = 0;
   localparam int STAT_FLAG = 1;
   localparam int STAT_DONE = 2;
   localparam logic [3:0] NCH_RST = 4'h1;
endpackage

// ==== qfd_link_if.sv ====
// Serial diagnostic link between a host controller and one driver device
`timescale 1ns/10ps
interface qfd_link_if;
   logic cs_n;        // Chip select, active low, from host
   logic sclk;        // Serial clock, from host
   logic cascade_in;  // Upstream serial data into the device
   logic sdo_o;       // Device open-drain data value
   logic sdo_oe_n;    // Device pulls the line low while this is low
   logic sdo_line;    // Resolved line with pull-up

   // Open-drain resolution with pull-up
   assign sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

   modport dev (input cs_n, input sclk, input cascade_in, output sdo_o, output sdo_oe_n);
   modport host (output cs_n, output sclk, input sdo_line);
endinterface

// ==== qfd_chan_fault.sv ====
// One output channel: protection, fault filtering and fault set requests
`timescale 1ns/10ps
module qfd_chan_fault import qfd_pkg::*; #(
   parameter int FILT_CYC_P = FILT_CYC
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   // Channel input and sensors (already synchronised)
   input  wire logic             i_in_on,
   input  wire logic             i_overtemp,
   input  wire logic             i_overcurrent,
   input  wire logic             i_sense_low,
   input  wire logic             i_sense_mid,
   // Output gate and fault set levels
   output logic                  o_drive,
   output logic [FLT_W-1:0]      o_set
);
   localparam int CW = $clog2(FILT_CYC_P + 1);

   logic [2:0] raw;
   logic [2:0] filt;
   logic       latch_ff;
   logic       nxt_latch;

   if (FILT_CYC_P < 1) begin : g_chk
      $error("FILT_CYC_P must be at least 1");
   end

   // Comparators in order: over-current, sense low, sense mid
   assign raw = {i_overcurrent, i_sense_low, i_sense_mid};

   // Transient filters: a comparator counts only after staying set
   for (genvar g = 0; g < 3; g++) begin : g_filt
      logic [CW-1:0] cnt_ff;
      always_ff @(posedge i_mclk) begin
         if (!i_rst_n || !raw[g]) begin
            cnt_ff <= '0;
         end else if (cnt_ff != CW'(FILT_CYC_P)) begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
      assign filt[g] = (cnt_ff == CW'(FILT_CYC_P));
   end

   // Short-to-supply latch: held until fault gone and input seen off
   assign nxt_latch = filt[2] | (latch_ff & i_in_on);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         latch_ff <= 1'b0;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   // Gate: thermal cut is direct and self-restoring, over-current latches
   assign o_drive = i_in_on & ~i_overtemp & ~latch_ff & ~filt[2];

   // Fault set levels, one per condition
   assign o_set[FLT_OT] = i_overtemp;
   assign o_set[FLT_SB] = filt[2];
   assign o_set[FLT_SG] = ~o_drive & filt[1];
   assign o_set[FLT_OL] = ~o_drive & filt[0];
endmodule

// ==== qfd_device.sv ====
// Quad driver device end: fault register, summary flag and serial readout
`timescale 1ns/10ps
module qfd_device import qfd_pkg::*; #(
   parameter int FILT_CYC_P = FILT_CYC
) (
   // Clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst_n,
   // Serial link
   qfd_link_if.dev                    link,
   // Channel inputs and sensors (asynchronous pins)
   input  wire logic [CH_N-1:0]       i_ch_in,
   input  wire logic [CH_N-1:0]       i_ch_overtemp,
   input  wire logic [CH_N-1:0]       i_ch_overcurrent,
   input  wire logic [CH_N-1:0]       i_ch_sense_low,
   input  wire logic [CH_N-1:0]       i_ch_sense_mid,
   // Channel gates and fault register view
   output logic [CH_N-1:0]            o_ch_drive,
   output logic [REG_W-1:0]           o_fault_reg
);
   logic [DEV_SYNC_W-1:0] meta_ff;
   logic [DEV_SYNC_W-1:0] sync_ff;
   logic                  cs_n_s;
   logic                  sclk_s;
   logic                  casc_s;
   logic [CH_N-1:0]       in_s;
   logic [CH_N-1:0]       ot_s;
   logic [CH_N-1:0]       oc_s;
   logic [CH_N-1:0]       low_s;
   logic [CH_N-1:0]       mid_s;

   logic                  cs_n_prev_ff;
   logic                  sclk_prev_ff;
   logic                  cs_fall;
   logic                  sclk_rise;
   logic                  sclk_fall;

   logic [REG_W-1:0]      fault_ff;
   logic [REG_W-1:0]      nxt_fault;
   logic [REG_W-1:0]      set_vec;
   logic [REG_W-1:0]      clr_mask;
   logic [REG_W-1:0]      sr_ff;
   logic                  flag_ff;
   logic                  gate_ff;
   logic                  data_ph_ff;
   logic                  hold_ff;
   logic                  sdo_ff;
   logic                  nxt_sdo;
   logic                  first_rise;
   logic                  shift_step;

   // Refuse a register width that the channel layout cannot fill
   if (FILT_CYC_P < 1 || REG_W != CH_N * FLT_W) begin : g_chk
      $error("qfd_device parameter out of range");
   end

   // Two-stage synchroniser for every pin
   // Only the second stage is read; the first may settle late
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         meta_ff <= DEV_SYNC_RST;
         sync_ff <= DEV_SYNC_RST;
      end else begin
         meta_ff <= {link.cs_n, link.sclk, link.cascade_in, i_ch_in, i_ch_overtemp,
                     i_ch_overcurrent, i_ch_sense_low, i_ch_sense_mid};
         sync_ff <= meta_ff;
      end
   end

   // Split synchronised pins
   // Field order must match the packing into meta_ff
   assign {cs_n_s, sclk_s, casc_s, in_s, ot_s, oc_s, low_s, mid_s} = sync_ff;

   // Previous levels for edge detection
   // Reset values are the idle levels, so no false edge follows reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cs_n_prev_ff <= 1'b1;
         sclk_prev_ff <= 1'b0;
      end else begin
         cs_n_prev_ff <= cs_n_s;
         sclk_prev_ff <= sclk_s;
      end
   end

   // Link events; clock edges count only while selected
   // A rise in the same cycle as select fall is not counted
   assign cs_fall   = cs_n_prev_ff & ~cs_n_s;
   assign sclk_rise = ~cs_n_s & ~cs_fall & ~sclk_prev_ff & sclk_s;
   assign sclk_fall = ~cs_n_s & sclk_prev_ff & ~sclk_s;

   // The first rise ends the summary; later rises shift
   assign first_rise = sclk_rise & ~data_ph_ff;
   assign shift_step = sclk_rise & data_ph_ff;

   // Per-channel protection and fault detection
   // Channel 0 fills the top nibble, which leaves first
   for (genvar c = 0; c < CH_N; c++) begin : g_ch
      qfd_chan_fault #(
         .FILT_CYC_P (FILT_CYC_P)
      ) u_chan (
         .i_mclk        (i_mclk),
         .i_rst_n       (i_rst_n),
         .i_in_on       (in_s[c]),
         .i_overtemp    (ot_s[c]),
         .i_overcurrent (oc_s[c]),
         .i_sense_low   (low_s[c]),
         .i_sense_mid   (mid_s[c]),
         .o_drive       (o_ch_drive[c]),
         .o_set         (set_vec[(CH_N-1-c)*FLT_W +: FLT_W])
      );
   end

   // Clear only what was snapshotted, on the first rising clock
   // Bits set after the snapshot survive to the next frame
   assign clr_mask  = first_rise ? sr_ff : '0;
   assign nxt_fault = (fault_ff & ~clr_mask) | set_vec;

   // Parallel fault register; a set beats a clear in the same cycle
   // Bits stay set until a readout clears them
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         fault_ff <= FAULT_RST;
      end else begin
         fault_ff <= nxt_fault;
      end
   end

   // Register view for the channel side
   assign o_fault_reg = fault_ff;

   // Snapshot, summary flag and gate at chip select fall
   // The summary is latched here and kept until the next select fall
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         flag_ff    <= 1'b0;
         gate_ff    <= 1'b0;
         data_ph_ff <= 1'b0;
      end else if (cs_fall) begin
         flag_ff    <= |fault_ff;
         gate_ff    <= ~sclk_s;
         data_ph_ff <= 1'b0;
      end else if (sclk_rise) begin
         gate_ff    <= 1'b0;
         data_ph_ff <= 1'b1;
      end
   end

   // Serial shifter: load, then advance on later rising clocks
   // Shift input comes from the bit held at the last falling clock
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sr_ff <= FAULT_RST;
      end else if (cs_fall) begin
         sr_ff <= fault_ff;
      end else if (shift_step) begin
         sr_ff <= {sr_ff[REG_W-2:0], hold_ff};
      end
   end

   // Upstream bit taken on falling clock while it is stable
   // Sampling at the fall keeps clear of upstream output changes
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || cs_fall) begin
         hold_ff <= 1'b0;
      end else if (sclk_fall) begin
         hold_ff <= casc_s;
      end
   end

   // Output bit: summary before the first clock, data after
   // Before the first rise the pin carries the wired-OR summary
   assign nxt_sdo = data_ph_ff ? sr_ff[REG_W-1]
                               : (flag_ff | (gate_ff & casc_s));

   // Output flop keeps decode glitches off the pin
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sdo_ff <= 1'b1;
      end else begin
         sdo_ff <= nxt_sdo;
      end
   end

   // Open drain: pull low only while selected and the bit is zero
   // A one is left to the pull-up, so the pin never fights it
   assign link.sdo_o    = sdo_ff;
   assign link.sdo_oe_n = cs_n_s | sdo_ff;
endmodule

// ==== qfd_host.sv ====
// Host end: Avalon-MM register slave that runs the serial fault readout
`timescale 1ns/10ps
module qfd_host import qfd_pkg::*; #(
   parameter int MAX_CHIPS = 2,
   parameter int HALF_CYC  = SCLK_HALF_CYC,
   parameter int SETUP_CYC = CS_SETUP_CYC
) (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Serial link
   qfd_link_if.host         link
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_END} qfd_state_e;

   localparam int BW = $clog2(MAX_CHIPS * REG_W);
   localparam int IW = (MAX_CHIPS > 1) ? $clog2(MAX_CHIPS) : 1;

   if (MAX_CHIPS < 1 || MAX_CHIPS > 2 || HALF_CYC < 4 || HALF_CYC > 255 ||
       SETUP_CYC < 4 || SETUP_CYC > 255) begin : g_chk
      $error("qfd_host parameter out of range");
   end

   qfd_state_e      st_ff;
   logic [7:0]      tmr_ff;
   logic [BW-1:0]   bit_ff;
   logic [REG_W-1:0] word_ff;
   logic [REG_W-1:0] nxt_word;
   logic [REG_W-1:0] data_ff [MAX_CHIPS];
   logic [3:0]      nch_ff;
   logic            flag_ff;
   logic            done_ff;
   logic            cs_n_ff;
   logic            sclk_ff;
   logic            meta_ff;
   logic            sdo_s_ff;
   logic            ack_ff;
   logic [31:0]     rdata_ff;
   logic            busy;
   logic            acc;
   logic            wr_now;
   logic            sel_ctrl;
   logic            sel_stat;
   logic            sel_data;
   logic [IW-1:0]   data_idx;
   logic            start;
   logic [3:0]      wr_nch;
   logic            last_bit;
   logic [31:0]     rd_mux;

   // Bus handshake: one wait state per access
   assign acc               = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = acc & ~ack_ff;
   assign wr_now            = i_avs_write & ack_ff;

   // Address decode
   assign sel_ctrl = (i_avs_address == REG_CTRL);
   assign sel_stat = (i_avs_address == REG_STAT);
   assign sel_data = (i_avs_address >= REG_DATA0) &&
                     ({1'b0, i_avs_address} < 5'(REG_DATA0) + 5'(4 * MAX_CHIPS));
   assign data_idx = IW'((i_avs_address - REG_DATA0) >> 2);
   assign start    = wr_now & sel_ctrl & i_avs_writedata[CTRL_START] & ~busy;
   assign wr_nch   = i_avs_writedata[CTRL_NCH_LSB +: CTRL_NCH_W];
   assign busy     = (st_ff != ST_IDLE);
   assign rd_mux   = sel_ctrl ? {20'h00000, nch_ff, 8'h00} :
                     sel_stat ? {29'h0, done_ff, flag_ff, busy} :
                     sel_data ? {16'h0000, data_ff[data_idx]} : 32'h0;

   // Bus registers
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0;
         nch_ff   <= NCH_RST;
      end else begin
         ack_ff   <= acc & ~ack_ff;
         rdata_ff <= rd_mux;
         if (wr_now && sel_ctrl && !busy && wr_nch != 4'h0 && wr_nch <= 4'(MAX_CHIPS)) begin
            nch_ff <= wr_nch;
         end
      end
   end

   assign o_avs_readdata = rdata_ff;

   // Line synchroniser
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         meta_ff  <= 1'b1;
         sdo_s_ff <= 1'b1;
      end else begin
         meta_ff  <= link.sdo_line;
         sdo_s_ff <= meta_ff;
      end
   end

   assign nxt_word = {word_ff[REG_W-2:0], sdo_s_ff};
   assign last_bit = (bit_ff == BW'({nch_ff, 4'h0} - 8'h01));

   // Readout sequence; clock idles low so select falls with it low
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st_ff   <= ST_IDLE;
         tmr_ff  <= 8'h00;
         bit_ff  <= '0;
         word_ff <= 16'h0000;
         cs_n_ff <= 1'b1;
         sclk_ff <= 1'b0;
         flag_ff <= 1'b0;
         done_ff <= 1'b0;
         for (int i = 0; i < MAX_CHIPS; i++) begin
            data_ff[i] <= 16'h0000;
         end
      end else begin
         if (tmr_ff != 8'h00) begin
            tmr_ff <= tmr_ff - 8'h01;
         end
         case (st_ff)
            ST_IDLE: begin
               if (start) begin
                  cs_n_ff <= 1'b0;
                  done_ff <= 1'b0;
                  tmr_ff  <= 8'(SETUP_CYC);
                  st_ff   <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (tmr_ff == 8'h00) begin
                  flag_ff <= sdo_s_ff;
                  bit_ff  <= '0;
                  if (!sdo_s_ff) begin
                     for (int i = 0; i < MAX_CHIPS; i++) begin
                        data_ff[i] <= 16'h0000;
                     end
                     cs_n_ff <= 1'b1;
                     tmr_ff  <= 8'(SETUP_CYC);
                     st_ff   <= ST_END;
                  end else begin
                     sclk_ff <= 1'b1;
                     tmr_ff  <= 8'(HALF_CYC - 1);
                     st_ff   <= ST_HIGH;
                  end
               end
            end
            ST_HIGH: begin
               if (tmr_ff == 8'h00) begin
                  sclk_ff <= 1'b0;
                  tmr_ff  <= 8'(HALF_CYC - 1);
                  st_ff   <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (tmr_ff == 8'h00) begin
                  word_ff <= nxt_word;
                  bit_ff  <= bit_ff + 1'b1;
                  if (bit_ff[3:0] == 4'hf) begin
                     data_ff[IW'(bit_ff >> 4)] <= nxt_word;
                  end
                  if (last_bit) begin
                     cs_n_ff <= 1'b1;
                     tmr_ff  <= 8'(SETUP_CYC);
                     st_ff   <= ST_END;
                  end else begin
                     sclk_ff <= 1'b1;
                     tmr_ff  <= 8'(HALF_CYC - 1);
                     st_ff   <= ST_HIGH;
                  end
               end
            end
            ST_END: begin
               if (tmr_ff == 8'h00) begin
                  done_ff <= 1'b1;
                  st_ff   <= ST_IDLE;
               end
            end
            default: begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   assign link.cs_n = cs_n_ff;
   assign link.sclk = sclk_ff;
endmodule

// ==== qfd_link_sva.sv ====
// Concurrent checks on the serial fault readout link
`timescale 1ns/10ps
module qfd_link_sva (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Link signals
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic cascade_in,
   input wire logic sdo_o,
   input wire logic sdo_oe_n,
   input wire logic sdo_line
);
   logic [3:0] cs_hi_ff;
   logic [3:0] nxt_cs_hi;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   // Cycles since chip select was last low, saturating
   assign nxt_cs_hi = (!cs_n) ? 4'h0 : ((cs_hi_ff == 4'hf) ? 4'hf : cs_hi_ff + 4'h1);

   // Counter register
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cs_hi_ff <= 4'hf;
      end else begin
         cs_hi_ff <= nxt_cs_hi;
      end
   end

   AST_RELEASED: assert property (cs_hi_ff >= 4'h6 |-> sdo_oe_n)
      else $error("data line driven while deselected");
   AST_OD_LOW: assert property (!sdo_oe_n |-> !sdo_o)
      else $error("data line enabled with a high bit");
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("serial clock high outside a frame");
   AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk [*8])
      else $error("serial clock rose too soon after select");
   AST_HIGH_HALF: assert property ($rose(sclk) |-> sclk [*4])
      else $error("serial clock high half too short");
   AST_LOW_HALF: assert property ($fell(sclk) |-> !sclk [*4])
      else $error("serial clock low half too short");
   AST_LINE_STABLE: assert property ($rose(sclk) |-> $past(sdo_line, 1) == $past(sdo_line, 2))
      else $error("data line moved just before a rising clock");
   AST_CASCADE_PASS: assert property ($fell(cs_n) && !sclk && cascade_in |-> ##6 sdo_line [*2])
      else $error("upstream summary not passed to the data line");

   // Main frames
   CVR_CASCADE: cover property ($fell(cs_n) && cascade_in);
   CVR_ALONE: cover property ($fell(cs_n) && !cascade_in);
   CVR_SHIFT: cover property ($rose(sclk) && !cs_n);
endmodule

// ==== testbench.sv ====
// Bench joining the host controller and the driver device over the link
`timescale 1ns/10ps
module testbench import qfd_pkg::*; ();
   logic        i_mclk    = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic [3:0]  avs_addr  = 4'h0;
   logic        avs_rd    = 1'b0;
   logic        avs_wr    = 1'b0;
   logic [31:0] avs_wdata = 32'h0;
   logic [31:0] avs_rdata;
   logic        avs_wait;
   logic [3:0]  ch_in     = 4'h0;
   logic [3:0]  ch_ot     = 4'h0;
   logic [3:0]  ch_oc     = 4'h0;
   logic [3:0]  ch_lo     = 4'h0;
   logic [3:0]  ch_mid    = 4'h0;
   logic [3:0]  ch_drive;
   logic [15:0] fault_reg;
   logic        cas_in    = 1'b0;
   logic        b_cs_n    = 1'b1;
   logic        b_sclk    = 1'b0;
   logic [31:0] rd;
   logic [31:0] st;
   int          fail_count  = 0;
   int          check_count = 0;

   qfd_link_if link ();
   qfd_link_if link_b ();
   // Bench-driven link pins
   assign link.cascade_in = cas_in;
   assign link_b.cs_n = b_cs_n;
   assign link_b.sclk = b_sclk;
   assign link_b.cascade_in = 1'b1;

   // Clock
   always #50 i_mclk = ~i_mclk;

   qfd_host #(.MAX_CHIPS(2)) u_qfd_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
      .i_avs_writedata(avs_wdata), .o_avs_readdata(avs_rdata),
      .o_avs_waitrequest(avs_wait), .link(link));
   qfd_device #(.FILT_CYC_P(3)) u_qfd_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .link(link), .i_ch_in(ch_in), .i_ch_overtemp(ch_ot), .i_ch_overcurrent(ch_oc),
      .i_ch_sense_low(ch_lo), .i_ch_sense_mid(ch_mid), .o_ch_drive(ch_drive),
      .o_fault_reg(fault_reg));
   qfd_device #(.FILT_CYC_P(3)) u_qfd_device_b (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .link(link_b), .i_ch_in(ch_in), .i_ch_overtemp(ch_ot), .i_ch_overcurrent(ch_oc),
      .i_ch_sense_low(ch_lo), .i_ch_sense_mid(ch_mid), .o_ch_drive(),
      .o_fault_reg());
   qfd_link_sva u_qfd_link_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .cs_n(link.cs_n),
      .sclk(link.sclk), .cascade_in(link.cascade_in), .sdo_o(link.sdo_o),
      .sdo_oe_n(link.sdo_oe_n), .sdo_line(link.sdo_line));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Waits n edges, then settles at the falling edge for sampling
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_mclk);
      @(negedge i_mclk);
   endtask

   // One Avalon access, held until waitrequest is seen low
   task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_mclk);
      avs_addr <= a;
      avs_wr <= wr;
      avs_rd <= !wr;
      avs_wdata <= wd;
      do begin
         @(negedge i_mclk);
         n++;
      end while (avs_wait !== 1'b0 && n < 20);
      if (avs_wait !== 1'b0) begin
         fail_count++;
         tally_and_finish();
      end
      q = avs_rdata;
      @(posedge i_mclk);
      avs_rd <= 1'b0;
      avs_wr <= 1'b0;
   endtask

   // Starts a readout of nch chips and polls until done
   task automatic run_read(input logic [3:0] nch);
      int n;
      n = 0;
      avs(1'b1, REG_CTRL, {20'h0, nch, 8'h01}, rd);
      do begin
         avs(1'b0, REG_STAT, 32'h0, st);
         n++;
      end while (st[STAT_DONE] !== 1'b1 && n < 400);
      if (st[STAT_DONE] !== 1'b1) begin
         fail_count++;
         tally_and_finish();
      end
   endtask

   task automatic pins(input logic [3:0] in, ot, oc, lo, mid);
      @(posedge i_mclk);
      ch_in <= in;
      ch_ot <= ot;
      ch_oc <= oc;
      ch_lo <= lo;
      ch_mid <= mid;
   endtask

   task automatic pin_b(input logic cs, input logic ck);
      @(posedge i_mclk);
      b_cs_n <= cs;
      b_sclk <= ck;
   endtask

   task automatic s_reset();
      check("fault reg", {16'h0, fault_reg}, 32'h0);
      check("drive", {28'h0, ch_drive}, 32'h0);
      avs(1'b0, REG_CTRL, 32'h0, rd);
      check("ctrl reset", rd, 32'h0000_0100);
      avs(1'b0, REG_STAT, 32'h0, rd);
      check("status reset", rd, 32'h0);
      avs(1'b1, 4'h2, 32'hffff_ffff, rd);
      avs(1'b0, 4'h2, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      avs(1'b1, REG_CTRL, 32'h0000_0300, rd);
      avs(1'b0, REG_CTRL, 32'h0, rd);
      check("count refused", rd, 32'h0000_0100);
   endtask

   // Upstream summary and upstream group after the own group
   task automatic s_cascade();
      @(posedge i_mclk);
      cas_in <= 1'b1;
      run_read(4'h2);
      check("cascade flag", {31'h0, st[STAT_FLAG]}, 32'h1);
      avs(1'b0, REG_DATA0, 32'h0, rd);
      check("own group", rd, 32'h0);
      avs(1'b0, REG_DATA0 + 4'h4, 32'h0, rd);
      check("upstream group", rd, 32'h0000_ffff);
      @(posedge i_mclk);
      cas_in <= 1'b0;
   endtask

   // Each fault kind on every channel, rotated over four passes
   task automatic s_faults();
      logic [15:0] exp;
      logic [3:0]  on;
      int          c_ot;
      int          c_sb;
      int          c_sg;
      int          c_ol;
      for (int k = 0; k < 4; k++) begin
         c_ot = k;
         c_sb = (k + 1) % 4;
         c_sg = (k + 2) % 4;
         c_ol = (k + 3) % 4;
         exp = 16'h0;
         exp[(3 - c_ot) * 4 + FLT_OT] = 1'b1;
         exp[(3 - c_sb) * 4 + FLT_SB] = 1'b1;
         exp[(3 - c_sg) * 4 + FLT_SG] = 1'b1;
         exp[(3 - c_ol) * 4 + FLT_OL] = 1'b1;
         on = (4'h1 << c_ot) | (4'h1 << c_sb);
         pins(on, 4'h1 << c_ot, 4'h1 << c_sb, 4'h1 << c_sg, 4'h1 << c_ol);
         wait_cyc(30);
         check("gate cut", {28'h0, ch_drive & on}, 32'h0);
         check("fault set", {16'h0, fault_reg}, {16'h0, exp});
         pins(on, 4'h0, 4'h0, 4'h0, 4'h0);
         wait_cyc(30);
         check("fault kept", {16'h0, fault_reg}, {16'h0, exp});
         check("gate back", {28'h0, ch_drive}, {28'h0, 4'h1 << c_ot});
         pins(4'h1 << c_ot, 4'h0, 4'h0, 4'h0, 4'h0);
         wait_cyc(30);
         pins(on, 4'h0, 4'h0, 4'h0, 4'h0);
         wait_cyc(10);
         check("gate relit", {28'h0, ch_drive}, {28'h0, on});
         run_read(4'h1);
         check("fault flag", {31'h0, st[STAT_FLAG]}, 32'h1);
         avs(1'b0, REG_DATA0, 32'h0, rd);
         check("shift order", rd, {16'h0, exp});
         check("fault cleared", {16'h0, fault_reg}, 32'h0);
         pins(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
         run_read(4'h1);
         check("clear flag", {31'h0, st[STAT_FLAG]}, 32'h0);
         avs(1'b0, REG_DATA0, 32'h0, rd);
         check("clear data", rd, 32'h0);
      end
   endtask

   // Second device: clock high at select blocks the upstream summary
   task automatic s_gate();
      pin_b(1'b0, 1'b0);
      wait_cyc(10);
      pin_b(1'b0, 1'b1);
      wait_cyc(8);
      pin_b(1'b0, 1'b0);
      wait_cyc(8);
      pin_b(1'b1, 1'b0);
      wait_cyc(10);
      check("idle line", {31'h0, link_b.sdo_line}, 32'h1);
      pin_b(1'b1, 1'b1);
      wait_cyc(4);
      pin_b(1'b0, 1'b1);
      wait_cyc(10);
      check("gate closed", {31'h0, link_b.sdo_line}, 32'h0);
      pin_b(1'b1, 1'b1);
      wait_cyc(4);
      pin_b(1'b1, 1'b0);
      wait_cyc(6);
      pin_b(1'b0, 1'b0);
      wait_cyc(10);
      check("gate open", {31'h0, link_b.sdo_line}, 32'h1);
      pin_b(1'b1, 1'b0);
      wait_cyc(10);
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      wait_cyc(4);
      s_reset();
      s_cascade();
      s_faults();
      s_gate();
      tally_and_finish();
   end
endmodule
